//--- logic/adcsp_top.sv
/*
 * Converter sequencer: normal modes, priority conversion, result
 * mapping and result monitor, with its register port.
 * Assumes a converter core that starts on conv_start (a start while it
 * runs aborts and restarts it) and answers with one conv_done pulse.
 */
// The placing of the registers and the strobed register port were left to the implementer.
// Notes on behaviour
// - Scan repeat: each full scan sets end flag and interrupt, busy stays one.
// - Reading the mode register clears the normal end flag.
// - Repeat bit cleared: finish current conversion, stop, clear busy.
// - Priority conversion is always fixed-channel single, mode bits ignored.
// - Priority done: interrupt, priority end flag set, priority busy cleared.
// - Reading the priority register clears the priority end flag.
// - Fixed single: end flag and interrupt after one conversion, busy zero.
// - Fixed repeat interval codes 00, 01, 10 mean every 1, 4, 8 conversions.
// - Scan single: end flag and interrupt once after scan, busy zero.
// - Priority starts by software bit or trigger chosen by trigger bits 7:6.
// - Priority preempts normal conversion; normal resumes at interrupted channel.
// - Priority request while priority busy is ignored.
// - Monitor compares selected result to compare value, direction chosen.
// - Monitor compares on every write to the monitored slot.
// - Fixed repeat: slot zero only for every-one, slots 0-3 for every-four.
// - Other modes store in slot channel modulo eight.
// - Writing one to the normal start bit starts the selected mode.
// - Normal busy set at start; kept with end flag during priority.
`default_nettype none
module adcsp_top (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst_b,
    // Register port
    input  wire logic [adcsp_pkg::AW-1:0]   reg_addr,
    input  wire logic [adcsp_pkg::DW-1:0]   reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [adcsp_pkg::DW-1:0]   reg_rdata,
    // Hardware triggers
    input  wire logic                       trig_pin_n,
    input  wire logic                       trig_timer_norm,
    input  wire logic                       trig_timer_prio,
    // Converter core
    output logic                            conv_start,
    output logic      [adcsp_pkg::CHW-1:0]  conv_chan,
    input  wire logic                       conv_done,
    input  wire logic [adcsp_pkg::RW-1:0]   conv_result,
    // Events
    output logic                            conv_done_irq,
    output logic                            prio_done_irq,
    output logic                            monitor_irq
);
    import adcsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        adcsp_state_t   st;
        logic           rd_ctl;
        logic [DW-1:0]  rdata;
        logic           scan;
        logic           repeat_bit;
        logic [1:0]     itm;
        logic [CHW-1:0] chan;
        logic [CHW-1:0] pchan;
        logic [3:0]     trig;
        logic           mon_en;
        logic           mon_dir;
        logic [CHW-1:0] mon_sel;
        logic [RW-1:0]  mon_cmp;
        logic           nbusy;
        logic           nend;
        logic           pbusy;
        logic           pend;
        logic           m_scan;
        logic           m_rep;
        logic [CHW-1:0] cur_ch;
        logic [2:0]     cnt;
        logic           resume;
        logic           start;
        logic [CHW-1:0] cch;
        logic           irq_n;
        logic           irq_p;
        logic           irq_m;
        logic           pin_q;
    } adcsp_regs_t;

    adcsp_regs_t    r;
    adcsp_regs_t    n;
    logic           rst_q1;
    logic           rst_n;
    logic           fixed_rep;
    logic [2:0]     last_cnt;
    logic           unit_end;
    logic [CHW-1:0] norm_idx;
    logic           mem_we;
    logic [CHW-1:0] mem_widx;
    logic           pin_fall;
    logic           hw_norm;
    logic           hw_prio;
    logic           sw_nstart;
    logic           prio_req;
    logic           mon_hit;
    logic           rd_res;
    logic [DW-1:0]  mem_rd;

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign fixed_rep = r.m_rep && !r.m_scan;
    // Interval code 11 is reserved and behaves as every conversion
    assign last_cnt = (r.itm == ITM_EVERY4) ? LAST_OF4 :
                      (r.itm == ITM_EVERY8) ? LAST_OF8 : 3'h0;
    assign unit_end = r.m_scan ? (r.cur_ch >= r.chan) :
                      (!r.m_rep || (r.cnt == last_cnt));
    assign norm_idx = !fixed_rep ? {1'b0, r.cur_ch[2:0]} :
                      (r.itm == ITM_EVERY4) ? {2'b00, r.cnt[1:0]} :
                      (r.itm == ITM_EVERY8) ? {1'b0, r.cnt} : 4'h0;
    assign mem_we   = conv_done && (r.st != ADCSP_IDLE);
    assign mem_widx = (r.st == ADCSP_PRIO) ? PRIO_SLOT : norm_idx;

    assign pin_fall  = r.pin_q && !trig_pin_n;
    assign hw_norm   = r.trig[T_N_EN] && (r.trig[T_N_SRC] ? trig_timer_norm : pin_fall);
    assign hw_prio   = r.trig[T_P_EN] && (r.trig[T_P_SRC] ? trig_timer_prio : pin_fall);
    assign sw_nstart = reg_wr && (reg_addr == OFS_MODE0) && reg_wdata[B_START];
    assign prio_req  = hw_prio ||
                       (reg_wr && (reg_addr == OFS_PRIO) && reg_wdata[B_PSTART]);

    assign mon_hit = r.mon_en && mem_we && (mem_widx == r.mon_sel) &&
                     (r.mon_dir ? (conv_result > r.mon_cmp) : (conv_result < r.mon_cmp));

    assign rd_res = ((reg_addr >= OFS_RES_FIRST) && (reg_addr <= OFS_RES_LAST)) ||
                    (reg_addr == OFS_PRES);

    adcsp_result_mem u_mem (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .wr_en   (mem_we),
        .wr_idx  (mem_widx),
        .wr_data (conv_result),
        .rd_en   (reg_rd && rd_res),
        .rd_idx  ((reg_addr == OFS_PRES) ? PRIO_SLOT : {1'b0, reg_addr[2:0]}),
        .rd_data (mem_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        n        = r;
        n.start  = 1'b0;
        n.irq_n  = 1'b0;
        n.irq_p  = 1'b0;
        n.irq_m  = mon_hit;
        n.pin_q  = trig_pin_n;
        n.rdata  = '0;
        n.rd_ctl = !(reg_rd && rd_res);

        // Reads first, so a flag set later in this cycle wins over the clear
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_MODE0: begin
                    n.rdata = {8'h00, r.nend, r.nbusy, 1'b0, r.itm,
                               r.repeat_bit, r.scan, 1'b0};
                    n.nend  = 1'b0;
                end
                OFS_CHAN:   n.rdata = {12'h000, r.chan};
                OFS_PRIO: begin
                    n.rdata = {8'h00, r.pend, r.pbusy, 2'b00, r.pchan};
                    n.pend  = 1'b0;
                end
                OFS_TRIG:   n.rdata = {8'h00, r.trig, 4'h0};
                OFS_MONCTL: n.rdata = {8'h00, r.mon_en, 2'b00, r.mon_dir, r.mon_sel};
                OFS_MONCMP: n.rdata = {{(DW-RW){1'b0}}, r.mon_cmp};
                default:    n.rdata = '0;
            endcase
        end

        if (reg_wr) begin
            unique case (reg_addr)
                OFS_MODE0: begin
                    n.scan       = reg_wdata[B_SCAN];
                    n.repeat_bit = reg_wdata[B_REPEAT];
                    n.itm        = reg_wdata[B_ITM +: 2];
                end
                OFS_CHAN:   n.chan    = reg_wdata[CHW-1:0];
                OFS_PRIO:   n.pchan   = reg_wdata[CHW-1:0];
                OFS_TRIG:   n.trig    = reg_wdata[B_TRG +: 4];
                OFS_MONCTL: begin
                    n.mon_sel = reg_wdata[CHW-1:0];
                    n.mon_dir = reg_wdata[B_MON_DIR];
                    n.mon_en  = reg_wdata[B_MON_EN];
                end
                OFS_MONCMP: n.mon_cmp = reg_wdata[RW-1:0];
                default: begin
                end
            endcase
        end

        // Conversion finished
        if (conv_done) begin
            unique case (r.st)
                ADCSP_NORMAL: begin
                    n.cnt = unit_end ? 3'h0 : r.cnt + 3'h1;
                    if (unit_end) begin
                        n.nend  = 1'b1;
                        n.irq_n = 1'b1;
                    end
                    if ((!r.m_rep && unit_end) || (r.m_rep && !r.repeat_bit)) begin
                        n.nbusy = 1'b0;
                        n.st    = ADCSP_IDLE;
                    end else begin
                        n.cur_ch = !r.m_scan ? r.cur_ch :
                                   (unit_end ? 4'h0 : r.cur_ch + 4'h1);
                        n.start  = 1'b1;
                        n.cch    = n.cur_ch;
                    end
                end
                ADCSP_PRIO: begin
                    n.pend  = 1'b1;
                    n.pbusy = 1'b0;
                    n.irq_p = 1'b1;
                    n.st    = r.resume ? ADCSP_NORMAL : ADCSP_IDLE;
                    if (r.resume) begin
                        n.start  = 1'b1;
                        n.cch    = r.cur_ch;
                        n.resume = 1'b0;
                    end
                end
                ADCSP_IDLE: begin
                end
                default: n.st = ADCSP_IDLE;
            endcase
        end

        // A start while normal or priority busy is dropped; a start is taken again once busy has cleared
        if ((sw_nstart || hw_norm) && !n.nbusy && !n.pbusy) begin
            n.nbusy  = 1'b1;
            n.m_scan = n.scan;
            n.m_rep  = n.repeat_bit;
            n.cur_ch = n.scan ? 4'h0 : n.chan;
            n.cnt    = 3'h0;
            n.st     = ADCSP_NORMAL;
            n.start  = 1'b1;
            n.cch    = n.cur_ch;
        end

        // Priority ignores mode bits; normal flags stay as they were
        if (prio_req && !r.pbusy) begin
            n.pbusy  = 1'b1;
            n.resume = (n.st == ADCSP_NORMAL);
            n.st     = ADCSP_PRIO;
            n.start  = 1'b1;
            n.cch    = n.pchan;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r       <= '0;
            r.pin_q <= PIN_IDLE;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign reg_rdata     = r.rd_ctl ? r.rdata : mem_rd;
    assign conv_start    = r.start;
    assign conv_chan     = r.cch;
    assign conv_done_irq = r.irq_n;
    assign prio_done_irq = r.irq_p;
    assign monitor_irq   = r.irq_m;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_single_end: assert property (
        (r.st == ADCSP_NORMAL) && conv_done && !r.m_rep && !r.m_scan &&
        !sw_nstart && !hw_norm |=> r.nend && !r.nbusy && conv_done_irq)
        else $error("fixed single end not flagged");

    a_scan_single: assert property (
        (r.st == ADCSP_NORMAL) && conv_done && !r.m_rep && r.m_scan &&
        (r.cur_ch >= r.chan) && !sw_nstart && !hw_norm
        |=> r.nend && !r.nbusy && conv_done_irq)
        else $error("scan single end not flagged");

    a_scan_repeat: assert property (
        (r.st == ADCSP_NORMAL) && conv_done && r.m_rep && r.m_scan && unit_end &&
        r.repeat_bit |=> r.nbusy && r.nend && conv_done_irq && conv_start)
        else $error("scan repeat end wrong");

    a_every4_gap: assert property (
        (r.st == ADCSP_NORMAL) && conv_done && fixed_rep && (r.itm == ITM_EVERY4) &&
        (r.cnt != 3'h3) |=> !conv_done_irq)
        else $error("interrupt before fourth conversion");

    a_every8_irq: assert property (
        (r.st == ADCSP_NORMAL) && conv_done && fixed_rep && (r.itm == ITM_EVERY8) &&
        (r.cnt == 3'h7) |=> conv_done_irq && r.nend && r.nbusy == $past(r.repeat_bit))
        else $error("no interrupt after eighth conversion");

    a_end_rd_clear: assert property (
        reg_rd && (reg_addr == OFS_MODE0) && !conv_done |=> !r.nend)
        else $error("normal end flag not cleared by read");

    a_stop_repeat: assert property (
        (r.st == ADCSP_NORMAL) && conv_done && r.m_rep && !r.repeat_bit &&
        !sw_nstart && !hw_norm |=> !r.nbusy)
        else $error("repeat did not stop");

    a_prio_end: assert property (
        (r.st == ADCSP_PRIO) && conv_done |=> r.pend && !r.pbusy && prio_done_irq)
        else $error("priority end not flagged");

    a_prio_rd_clear: assert property (
        reg_rd && (reg_addr == OFS_PRIO) && !conv_done |=> !r.pend)
        else $error("priority end flag not cleared by read");

    a_prio_ignore: assert property (
        r.pbusy && prio_req && !conv_done |=> !conv_start)
        else $error("priority request accepted while busy");

    a_prio_resume: assert property (
        (r.st == ADCSP_PRIO) && conv_done && r.resume
        |=> conv_start && (conv_chan == $past(r.cur_ch)) && (r.st == ADCSP_NORMAL))
        else $error("normal conversion not resumed");

    a_prio_keep: assert property (
        (r.st == ADCSP_PRIO) && !conv_done |=> r.nbusy == $past(r.nbusy))
        else $error("normal busy changed during priority");

    a_prio_fixed: assert property (
        prio_req && !r.pbusy && !reg_wr |=> conv_start && (conv_chan == $past(r.pchan)))
        else $error("priority conversion not on its channel");

    a_fixed_slot: assert property (
        mem_we && (r.st == ADCSP_NORMAL) && fixed_rep && (r.itm == ITM_EVERY1)
        |-> mem_widx == 4'h0)
        else $error("every-one result not in slot zero");

    a_mod8_slot: assert property (
        mem_we && (r.st == ADCSP_NORMAL) && !fixed_rep |-> mem_widx == {1'b0, r.cur_ch[2:0]})
        else $error("result slot not channel modulo eight");

    a_monitor_hit: assert property (
        mem_we && r.mon_en && r.mon_dir && (mem_widx == r.mon_sel) &&
        (conv_result > r.mon_cmp) |=> monitor_irq)
        else $error("monitor missed a greater result");

    a_start_busy: assert property (
        sw_nstart && !r.nbusy && !r.pbusy && !conv_done && !prio_req
        |=> r.nbusy && conv_start && (r.st == ADCSP_NORMAL))
        else $error("normal start not taken");

    c_scan_repeat: cover property (
        (r.st == ADCSP_NORMAL) && conv_done && r.m_rep && r.m_scan && unit_end);
    c_preempt: cover property ((r.st == ADCSP_NORMAL) && prio_req && !r.pbusy);
    c_monitor: cover property (monitor_irq);
    c_every4: cover property (conv_done_irq && fixed_rep && (r.itm == ITM_EVERY4));

endmodule
`default_nettype wire

//--- logic/adcsp_pkg.sv
/*
 * Shared constants for the converter sequencer: register map, field
 * positions, reset values and the sequencer state type.
 * Assumes a single system clock and a 5-bit word-indexed register port.
 */
`default_nettype none
package adcsp_pkg;

    // Widths
    localparam int AW    = 5;
    localparam int DW    = 16;
    localparam int RW    = 10;
    localparam int CHW   = 4;
    localparam int NSLOT = 9;

    // Register offsets (word index)
    localparam logic [AW-1:0] OFS_MODE0    = 5'h00;
    localparam logic [AW-1:0] OFS_CHAN     = 5'h01;
    localparam logic [AW-1:0] OFS_PRIO     = 5'h02;
    localparam logic [AW-1:0] OFS_TRIG     = 5'h03;
    localparam logic [AW-1:0] OFS_MONCTL   = 5'h04;
    localparam logic [AW-1:0] OFS_MONCMP   = 5'h05;
    localparam logic [AW-1:0] OFS_RES_FIRST = 5'h08;
    localparam logic [AW-1:0] OFS_RES_LAST = 5'h0f;
    localparam logic [AW-1:0] OFS_PRES     = 5'h10;

    // Field positions
    localparam int B_START   = 0;
    localparam int B_SCAN    = 1;
    localparam int B_REPEAT  = 2;
    localparam int B_ITM     = 3;
    localparam int B_PSTART  = 5;
    localparam int B_TRG     = 4;
    localparam int B_MON_DIR = 4;
    localparam int B_MON_EN  = 7;
    localparam int T_P_EN    = 3;
    localparam int T_P_SRC   = 2;
    localparam int T_N_EN    = 1;
    localparam int T_N_SRC   = 0;

    // Interval field codes
    localparam logic [1:0] ITM_EVERY1 = 2'h0;
    localparam logic [1:0] ITM_EVERY4 = 2'h1;
    localparam logic [1:0] ITM_EVERY8 = 2'h2;

    // Counts, slots and reset values
    localparam logic [2:0]     LAST_OF4  = 3'h3;
    localparam logic [2:0]     LAST_OF8  = 3'h7;
    localparam logic [CHW-1:0] PRIO_SLOT = 4'h8;
    localparam logic           PIN_IDLE  = 1'b1;

    typedef enum logic [1:0] {
        ADCSP_IDLE,
        ADCSP_NORMAL,
        ADCSP_PRIO
    } adcsp_state_t;

endpackage
`default_nettype wire

//--- logic/adcsp_result_mem.sv
/*
 * Result store: eight normal result slots and one priority slot, each
 * with a stored flag and an overrun flag. Read data come from a register.
 * Assumes at most one write and one read per cycle.
 */
`default_nettype none
module adcsp_result_mem (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    // Write side
    input  wire logic                       wr_en,
    input  wire logic [adcsp_pkg::CHW-1:0]  wr_idx,
    input  wire logic [adcsp_pkg::RW-1:0]   wr_data,
    // Read side
    input  wire logic                       rd_en,
    input  wire logic [adcsp_pkg::CHW-1:0]  rd_idx,
    output logic      [adcsp_pkg::DW-1:0]   rd_data
);
    import adcsp_pkg::*;

    typedef struct packed {
        logic [NSLOT-1:0][RW+1:0] ent;
        logic [DW-1:0]            rd;
    } adcsp_mem_t;

    adcsp_mem_t r;
    adcsp_mem_t n;

    always_comb begin
        n = r;
        if (rd_en) begin
            n.rd = {r.ent[rd_idx][RW+1], r.ent[rd_idx][RW],
                    {(DW-RW-2){1'b0}}, r.ent[rd_idx][RW-1:0]};
            // Only a read releases the flags; an unread slot keeps both set
            n.ent[rd_idx][RW+1:RW] = 2'b00;
        end
        // A new result wins over a read clear in the same cycle
        if (wr_en) begin
            n.ent[wr_idx] = {1'b1, r.ent[wr_idx][RW+1], wr_data};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign rd_data = r.rd;

endmodule
`default_nettype wire

//--- testbench/adcsp_core_model.sv
/*
 * Behavioural model of the analog converter core beside the sequencer.
 * Assumes one start pulse per conversion; a start while busy restarts it.
 */
`default_nettype none
module adcsp_core_model
    import adcsp_pkg::*;
(
    // Clock and latency select
    input  wire logic               mclk,
    input  wire logic [3:0]         lat,
    // Sequencer side
    input  wire logic               conv_start,
    input  wire logic [CHW-1:0]     conv_chan,
    output logic                    conv_done,
    output logic      [RW-1:0]      conv_result
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0]     cnt = 4'h0;
    logic           run = 1'b0;
    logic [CHW-1:0] ch  = 4'h0;
    initial conv_done   = 1'b0;
    initial conv_result = 10'h000;
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        conv_done   <= 1'b0;
        // Result bus is not held outside the done cycle
        conv_result <= ~conv_result;
        if (conv_start) begin
            run <= 1'b1;
            cnt <= lat;
            ch  <= conv_chan;
        end else if (run && cnt == 4'h0) begin
            run         <= 1'b0;
            conv_done   <= 1'b1;
            conv_result <= {ch, 6'h15};
        end else if (run) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

//--- testbench/adcsp_top_tb.sv
/*
 * Self-checking bench for the converter sequencer.
 * Assumes the core model file and the design package are compiled first.
 */
`default_nettype none
module adcsp_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import adcsp_pkg::*;
    localparam int IRQ = 0, PIRQ = 1, MON = 2, STA = 3, DON = 4;
    logic mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, trig_pin_n = 1'b1;
    logic trig_timer_norm = 1'b0, trig_timer_prio = 1'b0;
    logic conv_start, conv_done, conv_done_irq, prio_done_irq, monitor_irq;
    logic [AW-1:0]  reg_addr  = 5'h00;
    logic [DW-1:0]  reg_wdata = 16'h0000;
    logic [DW-1:0]  reg_rdata;
    logic [CHW-1:0] conv_chan;
    logic [3:0]     lat = 4'h2;
    logic [RW-1:0]  conv_result;
    int             error_cnt = 0, check_count = 0;
    int             n [5] = '{default: 0};
    ////////////////////////////////////////////////////////////////////////////
    adcsp_top DUT (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_pin_n(trig_pin_n),
        .trig_timer_norm(trig_timer_norm), .trig_timer_prio(trig_timer_prio),
        .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done),
        .conv_result(conv_result), .conv_done_irq(conv_done_irq),
        .prio_done_irq(prio_done_irq), .monitor_irq(monitor_irq));
    adcsp_core_model core (.mclk(mclk), .lat(lat), .conv_start(conv_start),
        .conv_chan(conv_chan), .conv_done(conv_done), .conv_result(conv_result));
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        n[IRQ]  += int'(conv_done_irq);
        n[PIRQ] += int'(prio_done_irq);
        n[MON]  += int'(monitor_irq);
        n[STA]  += int'(conv_start);
        n[DON]  += int'(conv_done);
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [DW-1:0] got, logic [DW-1:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rdv(logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask
    task automatic rd(logic [AW-1:0] a, logic [DW-1:0] e, string nm);
        logic [DW-1:0] d;
        rdv(a, d);
        chk(nm, d, e);
    endtask
    task automatic clr();
        @(negedge mclk);
        n = '{default: 0};
    endtask
    // Bounded wait: a stuck design falls through and fails the next compare
    task automatic wait_for(int idx, int cnt);
        repeat (3000) if (n[idx] < cnt) @(negedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_single();
        clr();
        wr(OFS_CHAN, 16'h000a);
        wr(OFS_MODE0, 16'h0001);
        wait_for(IRQ, 1);
        rd(OFS_MODE0, 16'h0080, "mode end");
        rd(OFS_MODE0, 16'h0000, "mode cleared");
        rd(OFS_RES_FIRST + 5'h02, 16'h8295, "slot 2");
        chk("irq count", 16'(n[IRQ]), 16'h0001);
    endtask
    task automatic t_scan();
        clr();
        wr(OFS_CHAN, 16'h0003);
        wr(OFS_MODE0, 16'h0003);
        wait_for(IRQ, 1);
        rd(OFS_MODE0, 16'h0082, "scan end");
        chk("scan count", 16'(n[IRQ] * 256 + n[DON]), 16'h0104);
    endtask
    task automatic t_repeat();
        logic [DW-1:0] md [4] = '{16'h0005, 16'h000d, 16'h0015, 16'h0007};
        int            k [4]  = '{1, 4, 8, 2};
        logic [DW-1:0] d;
        for (int i = 0; i < 4; i++) begin
            clr();
            wr(OFS_CHAN, md[i][1] ? 16'h0001 : 16'h0005);
            wr(OFS_MODE0, md[i]);
            wait_for(IRQ, 2);
            chk("done per irq", 16'(n[DON]), 16'(2 * k[i]));
            rdv(OFS_MODE0, d);
            chk("busy in repeat", d & 16'h0040, 16'h0040);
            wr(OFS_MODE0, md[i] & 16'h001a);
            repeat (40) @(negedge mclk);
            rdv(OFS_MODE0, d);
            chk("stopped", d & 16'h005f, md[i] & 16'h001a);
            clr();
            repeat (20) @(negedge mclk);
            chk("no restart", 16'(n[STA]), 16'h0000);
            if (i < 2) begin
                rdv(OFS_RES_FIRST + (i ? 5'h03 : 5'h05), d);
                chk("slot map", d & 16'h03ff, i ? 16'h0155 : 16'h0000);
            end
        end
    endtask
    task automatic t_prio();
        clr();
        lat <= 4'h9;
        wr(OFS_CHAN, 16'h0003);
        wr(OFS_MODE0, 16'h0001);
        wr(OFS_PRIO, 16'h002c);
        wr(OFS_PRIO, 16'h002c);
        wait_for(IRQ, 1);
        chk("starts", 16'(n[STA]), 16'h0003);
        chk("prio irq", 16'(n[PIRQ]), 16'h0001);
        rd(OFS_PRIO, 16'h008c, "prio end");
        rd(OFS_PRIO, 16'h000c, "prio cleared");
        rd(OFS_PRES, 16'h8315, "prio result");
        rd(OFS_RES_FIRST + 5'h03, 16'hc0d5, "resumed slot");
        wr(OFS_MODE0, 16'h0006);
        for (int s = 0; s < 2; s++) begin
            clr();
            wr(OFS_TRIG, s ? 16'h00c0 : 16'h0080);
            @(posedge mclk);
            if (s) trig_timer_prio <= 1'b1;
            else trig_pin_n <= 1'b0;
            @(posedge mclk);
            trig_timer_prio <= 1'b0;
            trig_pin_n      <= 1'b1;
            wait_for(PIRQ, 1);
            repeat (30) @(negedge mclk);
            chk("hw prio", 16'(n[PIRQ] * 256 + n[DON]), 16'h0101);
            chk("no normal", 16'(n[IRQ]), 16'h0000);
        end
        wr(OFS_TRIG, 16'h0000);
    endtask
    // Pass 2 starts from the normal timer trigger and checks the greater direction
    task automatic t_mon();
        for (int s = 0; s < 3; s++) begin
            clr();
            wr(OFS_MONCTL, (s == 1) ? 16'h0082 : 16'h0092);
            wr(OFS_MONCMP, (s == 2) ? 16'h0050 : 16'h0100);
            wr(OFS_CHAN, 16'h0002);
            if (s == 2) begin
                wr(OFS_TRIG, 16'h0030);
                @(posedge mclk);
                trig_timer_norm <= 1'b1;
                @(posedge mclk);
                trig_timer_norm <= 1'b0;
            end else begin
                wr(OFS_MODE0, 16'h0001);
            end
            wait_for(IRQ, 1);
            @(negedge mclk);
            chk("monitor", 16'(n[MON]), s ? 16'h0001 : 16'h0000);
        end
        rd(OFS_MONCMP, 16'h0050, "compare readback");
        rd(OFS_MONCTL, 16'h0092, "monitor readback");
        rd(OFS_TRIG, 16'h0030, "trigger readback");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        t_single();
        t_scan();
        t_repeat();
        t_prio();
        t_mon();
        report_and_stop();
    end
    // The whole run needs under a thousand cycles; allow twenty thousand
    initial begin
        #(20000 * 100);
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire
